/* rtl/srl_decode.sv */
// Per-channel lookup of swing, boost and de-emphasis from pin codes.
// Assumes synchronised two-bit codes; any unknown code counts as mid.
`timescale 1ns/100ps
module srl_decode
	import srl_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       clk_en_i,
	// Pin codes
	input  wire logic [1:0] swing_pin_i,
	input  wire logic [1:0] boost_pin_i,
	input  wire logic [1:0] deemph_pin_i,
	input  wire logic       swing_nc_i,
	// Settings
	output logic      [1:0] swing_o,
	output logic      [1:0] boost_o,
	output logic      [2:0] deemph_o
);

	logic [1:0] swing_r;
	logic [1:0] swing_nxt;
	logic [1:0] boost_r;
	logic [1:0] boost_nxt;
	logic [2:0] deemph_r;
	logic [2:0] deemph_nxt;
	logic [1:0] sw_lvl;

	// Folds the spare code onto mid level
	function automatic logic [1:0] lvl(input logic [1:0] code);
		lvl = (code == PIN_LOW || code == PIN_HIGH) ? code : PIN_MID;
	endfunction

	// Lookup of the held codes
	always_comb
	begin
		sw_lvl = swing_nc_i ? PIN_MID : lvl(swing_pin_i);
		case (sw_lvl)
			PIN_LOW:  swing_nxt = SW_1105;
			PIN_HIGH: swing_nxt = SW_1324;
			default:  swing_nxt = SW_1241;
		endcase
		case (lvl(boost_pin_i))
			PIN_LOW:  boost_nxt = EQ_7DB;
			PIN_HIGH: boost_nxt = EQ_15DB;
			default:  boost_nxt = EQ_0DB;
		endcase
		deemph_nxt = DE_0DB;
		if (lvl(deemph_pin_i) == PIN_LOW)
		begin
			case (sw_lvl)
				PIN_LOW:  deemph_nxt = DE_M2DB;
				PIN_HIGH: deemph_nxt = DE_M4DB;
				default:  deemph_nxt = DE_M3DB;
			endcase
		end
		else if (lvl(deemph_pin_i) == PIN_HIGH)
		begin
			case (sw_lvl)
				PIN_LOW:  deemph_nxt = DE_M4DB;
				PIN_HIGH: deemph_nxt = DE_M56DB;
				default:  deemph_nxt = DE_M5DB;
			endcase
		end
		if (!clk_en_i)
		begin
			swing_nxt  = swing_r;
			boost_nxt  = boost_r;
			deemph_nxt = deemph_r;
		end
	end

	// Settings register, reset to the floating defaults
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			swing_r  <= SW_1241;
			boost_r  <= EQ_0DB;
			deemph_r <= DE_0DB;
		end
		else
		begin
			swing_r  <= swing_nxt;
			boost_r  <= boost_nxt;
			deemph_r <= deemph_nxt;
		end
	end

	assign swing_o  = swing_r;
	assign boost_o  = boost_r;
	assign deemph_o = deemph_r;

endmodule

/* rtl/srl_link_ctrl.sv */
// Link power control for a two-channel SuperSpeed redriver.
// Assumes analog front-end flags and all pins are asynchronous; they
// are synchronised here. Channel 1 faces the controller input side.
//
// Summary of operation
// - Enable low, or low at power-up, puts the device to sleep.
// - Enable defaults high (normal operation) when unconnected.
// - Sleep holds all terminations high impedance, operation stopped.
// - Sleep entry within 2 us; sleep exit to detect within 100 us.
// - Swing pin picks 1241 (mid), 1105 (low) or 1324 (high) mVpp.
// - Boost pin picks 0 dB (mid), 7 dB (low) or 15 dB (high).
// - De-emphasis decoded jointly from de-emphasis and swing pins.
// - Setting pins are three-level; floating or half supply is mid.
// - Small package: channel 2 swing always decodes as mid.
// - Link break or no receiver: detect mode, input terms high-Z.
// - Detect mode returns to normal by itself on reconnection.
// - Timers track U2/U3 entry; selected circuits off while idle.
// - LFPS activity in U2/U3 returns the link to active.
// - Power-up or enable toggle runs detection, input terms off.
// - Both receivers found: terminations switch to nominal.
// - Detection failed: transmitter high-Z, channel low power.
// - Failed detection retries every 12 ms until found or sleep.
// - U2/U3 periodic detection keeps input termination enabled.
// - U2/U3 detection: found returns low power, else redetect.
// - Input below LFPS threshold idles output; above resumes it.
`timescale 1ns/100ps
module srl_link_ctrl
	import srl_pkg::*;
#(
	parameter int P_WAKE_CYC  = WAKE_CYC,
	parameter int P_RETRY_CYC = RETRY_CYC,
	parameter int P_POLL_CYC  = POLL_CYC
)
(
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       clk_en_i,
	// Device control pins
	input  wire logic       enable_i,
	input  wire logic       small_pkg_i,
	// Three-level setting pins, two-bit codes
	input  wire logic [1:0] swing_select_ch1_i,
	input  wire logic [1:0] swing_select_ch2_i,
	input  wire logic [1:0] boost_select_ch1_i,
	input  wire logic [1:0] boost_select_ch2_i,
	input  wire logic [1:0] deemph_select_ch1_i,
	input  wire logic [1:0] deemph_select_ch2_i,
	// Analog front-end flags
	input  wire logic       far_term_ch1_i,
	input  wire logic       far_term_ch2_i,
	input  wire logic       lfps_act_ch1_i,
	input  wire logic       lfps_act_ch2_i,
	input  wire logic       rx_idle_ch1_i,
	input  wire logic       rx_idle_ch2_i,
	// Power and termination controls
	output logic            sleep_o,
	output logic            pwr_down_o,
	output logic            low_pwr_o,
	output logic            rx_term_en_o,
	output logic            tx_term_en_o,
	output logic            det_req_o,
	output logic            tx_idle_ch1_o,
	output logic            tx_idle_ch2_o,
	// Decoded settings
	output logic      [1:0] swing_ch1_o,
	output logic      [1:0] swing_ch2_o,
	output logic      [1:0] boost_ch1_o,
	output logic      [1:0] boost_ch2_o,
	output logic      [2:0] deemph_ch1_o,
	output logic      [2:0] deemph_ch2_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [SY_W-1:0]  sy;
	logic             en_s;
	logic             found;
	logic             act;
	logic             both_idle;
	srl_state_t       state_r;
	srl_state_t       state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             sleep_r;
	logic             sleep_nxt;
	logic             pdn_r;
	logic             pdn_nxt;
	logic             lpw_r;
	logic             lpw_nxt;
	logic             rxt_r;
	logic             rxt_nxt;
	logic             txt_r;
	logic             txt_nxt;
	logic             det_r;
	logic             det_nxt;
	logic             idl1_r;
	logic             idl1_nxt;
	logic             idl2_r;
	logic             idl2_nxt;

	// Timer limit reached
	function automatic logic hit(input logic [CNT_W-1:0] c,
		input int lim);
		hit = (c >= CNT_W'(lim - 1));
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	// Enable resets high, as if pulled up while unconnected
	srl_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.clk_en_i  (clk_en_i),
		.async_i   ({deemph_select_ch2_i, boost_select_ch2_i,
			swing_select_ch2_i, deemph_select_ch1_i,
			boost_select_ch1_i, swing_select_ch1_i,
			rx_idle_ch2_i, rx_idle_ch1_i,
			lfps_act_ch2_i, lfps_act_ch1_i,
			far_term_ch2_i, far_term_ch1_i,
			small_pkg_i, enable_i}),
		.sync_o    (sy)
	);

	// Synchronised flags
	assign en_s      = sy[SY_EN];
	assign found     = sy[SY_DET1] & sy[SY_DET2];
	assign act       = sy[SY_ACT1] | sy[SY_ACT2];
	assign both_idle = idl1_r & idl2_r;

	// ----------------------------------------------------------------
	// Setting decode
	// ----------------------------------------------------------------
	// Channel 1 settings
	srl_decode u_dec1 (
		.sys_clk_i    (sys_clk_i),
		.arst_n_i     (arst_n_i),
		.clk_en_i     (clk_en_i),
		.swing_pin_i  (sy[SY_PINS+1:SY_PINS]),
		.boost_pin_i  (sy[SY_PINS+3:SY_PINS+2]),
		.deemph_pin_i (sy[SY_PINS+5:SY_PINS+4]),
		.swing_nc_i   (1'b0),
		.swing_o      (swing_ch1_o),
		.boost_o      (boost_ch1_o),
		.deemph_o     (deemph_ch1_o)
	);

	// Channel 2 settings; swing pin unbonded in the small package
	srl_decode u_dec2 (
		.sys_clk_i    (sys_clk_i),
		.arst_n_i     (arst_n_i),
		.clk_en_i     (clk_en_i),
		.swing_pin_i  (sy[SY_PINS+7:SY_PINS+6]),
		.boost_pin_i  (sy[SY_PINS+9:SY_PINS+8]),
		.deemph_pin_i (sy[SY_PINS+11:SY_PINS+10]),
		.swing_nc_i   (sy[SY_SPKG]),
		.swing_o      (swing_ch2_o),
		.boost_o      (boost_ch2_o),
		.deemph_o     (deemph_ch2_o)
	);

	// ----------------------------------------------------------------
	// Link state machine
	// ----------------------------------------------------------------
	// Next state and timer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_SLEEP:
				if (en_s)
					state_nxt = ST_WAKE;
			ST_WAKE:
				if (hit(cnt_r, P_WAKE_CYC))
					state_nxt = ST_DETECT;
			ST_DETECT:
				if (hit(cnt_r, DET_CYC))
					state_nxt = found ? ST_ACTIVE : ST_RETRY;
			ST_RETRY:
				if (hit(cnt_r, P_RETRY_CYC))
					state_nxt = ST_DETECT;
			ST_ACTIVE:
				if (both_idle && hit(cnt_r, UIDLE_CYC))
					state_nxt = ST_LOWPWR;
			ST_LOWPWR:
				if (act)
					state_nxt = ST_ACTIVE;
				else if (hit(cnt_r, P_POLL_CYC))
					state_nxt = ST_LPDET;
			ST_LPDET:
				if (hit(cnt_r, DET_CYC))
					state_nxt = found ? ST_LOWPWR : ST_DETECT;
			default:
				state_nxt = ST_SLEEP;
		endcase
		if (!en_s)
			state_nxt = ST_SLEEP;
		if (state_nxt != state_r
			|| (state_r == ST_ACTIVE && !both_idle))
			cnt_nxt = '0;
		else if (hit(cnt_r, RETRY_CYC + 1))
			cnt_nxt = cnt_r;
		else
			cnt_nxt = cnt_r + CNT_W'(1);
		if (!clk_en_i)
		begin
			state_nxt = state_r;
			cnt_nxt   = cnt_r;
		end
	end

	// State registers; reset lands in sleep until enable is seen
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_r <= ST_SLEEP;
			cnt_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Power, termination and idle controls
	// ----------------------------------------------------------------
	// Controls follow the next state so they align with state_r
	always_comb
	begin
		sleep_nxt = (state_nxt == ST_SLEEP);
		pdn_nxt   = (state_nxt == ST_SLEEP || state_nxt == ST_WAKE
			|| state_nxt == ST_DETECT
			|| state_nxt == ST_RETRY);
		lpw_nxt   = (state_nxt == ST_LOWPWR
			|| state_nxt == ST_LPDET);
		rxt_nxt   = (state_nxt == ST_ACTIVE
			|| state_nxt == ST_LOWPWR
			|| state_nxt == ST_LPDET);
		txt_nxt   = rxt_nxt;
		det_nxt   = (state_nxt == ST_DETECT
			|| state_nxt == ST_LPDET);
		// Idle hysteresis: set below threshold, clear above
		idl1_nxt  = sy[SY_IDL1] ? 1'b1 :
			(sy[SY_ACT1] ? 1'b0 : idl1_r);
		idl2_nxt  = sy[SY_IDL2] ? 1'b1 :
			(sy[SY_ACT2] ? 1'b0 : idl2_r);
		if (!clk_en_i)
		begin
			sleep_nxt = sleep_r;
			pdn_nxt   = pdn_r;
			lpw_nxt   = lpw_r;
			rxt_nxt   = rxt_r;
			txt_nxt   = txt_r;
			det_nxt   = det_r;
			idl1_nxt  = idl1_r;
			idl2_nxt  = idl2_r;
		end
	end

	// Control registers, safe low-power values at reset
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sleep_r <= 1'b1;
			pdn_r   <= 1'b1;
			lpw_r   <= 1'b0;
			rxt_r   <= 1'b0;
			txt_r   <= 1'b0;
			det_r   <= 1'b0;
			idl1_r  <= 1'b1;
			idl2_r  <= 1'b1;
		end
		else
		begin
			sleep_r <= sleep_nxt;
			pdn_r   <= pdn_nxt;
			lpw_r   <= lpw_nxt;
			rxt_r   <= rxt_nxt;
			txt_r   <= txt_nxt;
			det_r   <= det_nxt;
			idl1_r  <= idl1_nxt;
			idl2_r  <= idl2_nxt;
		end
	end

	assign sleep_o       = sleep_r;
	assign pwr_down_o    = pdn_r;
	assign low_pwr_o     = lpw_r;
	assign rx_term_en_o  = rxt_r;
	assign tx_term_en_o  = txt_r;
	assign det_req_o     = det_r;
	assign tx_idle_ch1_o = idl1_r;
	assign tx_idle_ch2_o = idl2_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	localparam int A_DIS = 3;

	default clocking a_clk @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_sleep_entry: assert property (
		clk_en_i && !en_s |=> state_r == ST_SLEEP)
		else $error("no sleep after enable low");
	a_sleep_hiz: assert property (
		state_r == ST_SLEEP |-> sleep_o && !rx_term_en_o
		&& !tx_term_en_o && pwr_down_o)
		else $error("terminations active in sleep");
	a_sleep_time: assert property (
		$fell(sy[SY_EN]) && clk_en_i ##1 clk_en_i |-> ##[0:A_DIS]
		sleep_o)
		else $error("sleep entry too slow");
	a_wake_bound: assert property (
		state_r == ST_WAKE |-> cnt_r < CNT_W'(P_WAKE_CYC))
		else $error("sleep exit beyond limit");
	a_detect_rxhiz: assert property (
		state_r == ST_DETECT |-> det_req_o && !rx_term_en_o)
		else $error("input termination on during detect");
	a_term_found: assert property (
		clk_en_i && en_s && state_r == ST_DETECT
		&& hit(cnt_r, DET_CYC) && found |=> tx_term_en_o
		&& rx_term_en_o)
		else $error("terminations not nominal after detect");
	a_fail_retry: assert property (
		clk_en_i && en_s && state_r == ST_DETECT
		&& hit(cnt_r, DET_CYC) && !found |=> state_r == ST_RETRY
		&& !tx_term_en_o && pwr_down_o)
		else $error("failed detect not handled");
	a_retry_wait: assert property (
		state_r == ST_RETRY && state_nxt == ST_DETECT && en_s
		|-> cnt_r == CNT_W'(P_RETRY_CYC - 1))
		else $error("retry interval wrong");
	a_lfps_wake: assert property (
		clk_en_i && en_s && state_r == ST_LOWPWR && act
		|=> state_r == ST_ACTIVE && !low_pwr_o)
		else $error("no wake on activity");
	a_lpdet_term: assert property (
		state_r == ST_LPDET |-> rx_term_en_o && det_req_o)
		else $error("input termination dropped in U2/U3 detect");
	a_lpdet_fail: assert property (
		clk_en_i && en_s && state_r == ST_LPDET
		&& hit(cnt_r, DET_CYC) && !found |=> state_r == ST_DETECT
		&& !rx_term_en_o)
		else $error("U2/U3 detect failure not handled");
	a_idle_force: assert property (
		clk_en_i && sy[SY_IDL1] |=> tx_idle_ch1_o)
		else $error("idle not forced on channel 1");
	a_swing_nc: assert property (
		clk_en_i && sy[SY_SPKG] |=> swing_ch2_o == SW_1241)
		else $error("channel 2 swing not default");

	c_active: cover property (
		state_r == ST_DETECT ##1 state_r == ST_ACTIVE);
	c_retry: cover property (
		state_r == ST_RETRY ##1 state_r == ST_DETECT);
	c_lowpwr: cover property (
		state_r == ST_LOWPWR ##1 state_r == ST_ACTIVE);
	c_lpdet_fail: cover property (
		state_r == ST_LPDET ##1 state_r == ST_DETECT);

endmodule

/* rtl/srl_pkg.sv */
// Constants, encodings and state type for the redriver link control.
// Assumes a single 200 MHz system clock and three-level pins pre-coded
// into two-bit codes by the pad ring.
package srl_pkg;

	// ----------------------------------------------------------------
	// Three-level pin codes
	// ----------------------------------------------------------------
	localparam logic [1:0] PIN_LOW  = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_MID  = 2'h2;

	// ----------------------------------------------------------------
	// Setting encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SW_1105 = 2'h0;
	localparam logic [1:0] SW_1241 = 2'h1;
	localparam logic [1:0] SW_1324 = 2'h2;
	localparam logic [1:0] EQ_0DB  = 2'h0;
	localparam logic [1:0] EQ_7DB  = 2'h1;
	localparam logic [1:0] EQ_15DB = 2'h2;
	localparam logic [2:0] DE_0DB   = 3'h0;
	localparam logic [2:0] DE_M2DB  = 3'h1;
	localparam logic [2:0] DE_M3DB  = 3'h2;
	localparam logic [2:0] DE_M4DB  = 3'h3;
	localparam logic [2:0] DE_M5DB  = 3'h4;
	localparam logic [2:0] DE_M56DB = 3'h5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS      = 5;
	localparam int T_DIS_NS    = 2000;
	localparam int T_ENB_NS    = 100000;
	localparam int T_RETRY_MS  = 12;
	localparam int T_POLL_MS   = 12;
	localparam int T_DET_NS    = 1000;
	localparam int T_UIDLE_NS  = 10000;
	localparam int DIS_CYC     = T_DIS_NS / CLK_NS;
	localparam int WAKE_CYC    = T_ENB_NS / CLK_NS;
	localparam int RETRY_CYC   = T_RETRY_MS * 1000000 / CLK_NS;
	localparam int POLL_CYC    = T_POLL_MS * 1000000 / CLK_NS;
	localparam int DET_CYC     = (T_DET_NS + CLK_NS - 1) / CLK_NS;
	localparam int UIDLE_CYC   = (T_UIDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W       = 22;

	// ----------------------------------------------------------------
	// Synchroniser bit map
	// ----------------------------------------------------------------
	localparam int SY_W    = 20;
	localparam int SY_EN   = 0;
	localparam int SY_SPKG = 1;
	localparam int SY_DET1 = 2;
	localparam int SY_DET2 = 3;
	localparam int SY_ACT1 = 4;
	localparam int SY_ACT2 = 5;
	localparam int SY_IDL1 = 6;
	localparam int SY_IDL2 = 7;
	localparam int SY_PINS = 8;
	localparam logic [SY_W-1:0] SY_RST = 20'h00001;
	localparam logic [SY_W-1:0] SY_PIN_RST = 20'haaa00;

	// ----------------------------------------------------------------
	// Link state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_SLEEP  = 3'h0,
		ST_WAKE   = 3'h1,
		ST_DETECT = 3'h3,
		ST_ACTIVE = 3'h2,
		ST_LOWPWR = 3'h6,
		ST_LPDET  = 3'h7,
		ST_RETRY  = 3'h5
	} srl_state_t;

endpackage

/* rtl/srl_sync.sv */
// Two-flop synchroniser bank for pins and analog flags.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/100ps
module srl_sync
	import srl_pkg::*;
(
	// Clock and reset
	input  wire logic            sys_clk_i,
	input  wire logic            arst_n_i,
	input  wire logic            clk_en_i,
	// Data
	input  wire logic [SY_W-1:0] async_i,
	output logic      [SY_W-1:0] sync_o
);

	logic [SY_W-1:0] meta_r;
	logic [SY_W-1:0] meta_nxt;
	logic [SY_W-1:0] sync_r;
	logic [SY_W-1:0] sync_nxt;

	// Hold while the clock enable is low
	always_comb
	begin
		meta_nxt = clk_en_i ? async_i : meta_r;
		sync_nxt = clk_en_i ? meta_r : sync_r;
	end

	// Reset values put enable high and setting pins at mid level
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_r <= SY_RST | SY_PIN_RST;
			sync_r <= SY_RST | SY_PIN_RST;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_o = sync_r;

endmodule

/* tb/srl_afe_model.sv */
// Behavioural front end and far-end link for the link control.
// Assumes the bench commands receiver presence and line state.
`timescale 1ns/100ps
module srl_afe_model
(
	// Sense request from the link control
	input  wire logic det_req_i,
	// Bench commands, channel 1 is the controller side
	input  wire logic rcv1_i,
	input  wire logic rcv2_i,
	input  wire logic idle1_i,
	input  wire logic idle2_i,
	input  wire logic act1_i,
	input  wire logic act2_i,
	// Front-end flags
	output logic      far_term_ch1_o,
	output logic      far_term_ch2_o,
	output logic      lfps_act_ch1_o,
	output logic      lfps_act_ch2_o,
	output logic      rx_idle_ch1_o,
	output logic      rx_idle_ch2_o
);
	// A far termination is only seen while a sense is applied
	assign far_term_ch1_o = det_req_i & rcv1_i;
	assign far_term_ch2_o = det_req_i & rcv2_i;
	// Activity never reported on an idle input
	assign lfps_act_ch1_o = act1_i & ~idle1_i;
	assign lfps_act_ch2_o = act2_i & ~idle2_i;
	assign rx_idle_ch1_o  = idle1_i;
	assign rx_idle_ch2_o  = idle2_i;
endmodule

/* tb/tb_srl_link_ctrl.sv */
// Self-checking bench for the redriver link control.
// Assumes shortened timers and the behavioural front-end model.
`timescale 1ns/100ps
module tb_srl_link_ctrl
	import srl_pkg::*;
;
	localparam int WK = 4;
	localparam int RT = 50;
	localparam int PL = 50;
	localparam int S_DET = 0;
	localparam int S_SLP = 1;
	localparam int S_LPW = 2;
	localparam int S_RXT = 3;

	logic       sys_clk, arst_n, clk_en, enable, small_pkg;
	logic [1:0] sw1, sw2, bo1, bo2, de1, de2;
	logic       ft1, ft2, la1, la2, ri1, ri2;
	logic       rcv1, rcv2, idl1, idl2, act1, act2;
	logic       sleep, pwr_down, low_pwr, rx_term, tx_term, det_req;
	logic       txi1, txi2;
	logic [1:0] swing1, swing2, boost1, boost2;
	logic [2:0] deem1, deem2;
	int         mismatches, check_count, cycles, n;

	// -----------------------------------------------------------------
	// Design and far side
	// -----------------------------------------------------------------
	srl_link_ctrl #(.P_WAKE_CYC(WK), .P_RETRY_CYC(RT), .P_POLL_CYC(PL))
		srl_link_ctrl_i (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
		.clk_en_i(clk_en), .enable_i(enable), .small_pkg_i(small_pkg),
		.swing_select_ch1_i(sw1), .swing_select_ch2_i(sw2),
		.boost_select_ch1_i(bo1), .boost_select_ch2_i(bo2),
		.deemph_select_ch1_i(de1), .deemph_select_ch2_i(de2),
		.far_term_ch1_i(ft1), .far_term_ch2_i(ft2),
		.lfps_act_ch1_i(la1), .lfps_act_ch2_i(la2),
		.rx_idle_ch1_i(ri1), .rx_idle_ch2_i(ri2),
		.sleep_o(sleep), .pwr_down_o(pwr_down), .low_pwr_o(low_pwr),
		.rx_term_en_o(rx_term), .tx_term_en_o(tx_term),
		.det_req_o(det_req), .tx_idle_ch1_o(txi1), .tx_idle_ch2_o(txi2),
		.swing_ch1_o(swing1), .swing_ch2_o(swing2),
		.boost_ch1_o(boost1), .boost_ch2_o(boost2),
		.deemph_ch1_o(deem1), .deemph_ch2_o(deem2));
	srl_afe_model srl_afe_model_i (.det_req_i(det_req),
		.rcv1_i(rcv1), .rcv2_i(rcv2), .idle1_i(idl1), .idle2_i(idl2),
		.act1_i(act1), .act2_i(act2),
		.far_term_ch1_o(ft1), .far_term_ch2_o(ft2),
		.lfps_act_ch1_o(la1), .lfps_act_ch2_o(la2),
		.rx_idle_ch1_o(ri1), .rx_idle_ch2_o(ri2));

	// -----------------------------------------------------------------
	// Clock, hang guard and helpers
	// -----------------------------------------------------------------
	always #2.5 sys_clk = ~sys_clk;

	// Cut a hang short well beyond the expected run length
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk_flag(input logic got, input logic exp,
		input string msg);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic chk_set(input logic [2:0] got, input logic [2:0] exp,
		input string msg);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			S_DET:   pick = det_req;
			S_SLP:   pick = sleep;
			S_LPW:   pick = low_pwr;
			default: pick = rx_term;
		endcase
	endfunction

	// Bounded wait for a control output, n returns the cycles spent
	task automatic wait_until(input int sel, input logic val,
		input int lim, output int k);
		k = 0;
		while (pick(sel) !== val && k < lim)
		begin
			step(1);
			k++;
		end
		chk_flag(pick(sel), val, "control output did not arrive");
	endtask

	function automatic logic [1:0] exp_sw(input logic [1:0] c);
		exp_sw = (c == PIN_LOW) ? SW_1105 :
			(c == PIN_HIGH) ? SW_1324 : SW_1241;
	endfunction

	function automatic logic [1:0] exp_eq(input logic [1:0] c);
		exp_eq = (c == PIN_LOW) ? EQ_7DB :
			(c == PIN_HIGH) ? EQ_15DB : EQ_0DB;
	endfunction

	function automatic logic [2:0] exp_de(input logic [1:0] d,
		input logic [1:0] s);
		logic [1:0] w;
		w = exp_sw(s);
		if (d == PIN_LOW)
			exp_de = (w == SW_1241) ? DE_M3DB :
				(w == SW_1105) ? DE_M2DB : DE_M4DB;
		else if (d == PIN_HIGH)
			exp_de = (w == SW_1241) ? DE_M5DB :
				(w == SW_1105) ? DE_M4DB : DE_M56DB;
		else
			exp_de = DE_0DB;
	endfunction

	// -----------------------------------------------------------------
	// Test sequence
	// -----------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		{enable, clk_en, small_pkg} = 3'h6;
		{rcv1, rcv2, idl1, idl2, act1, act2} = 6'h30;
		{sw1, sw2, bo1, bo2, de1, de2} = {6{PIN_MID}};
		step(5);
		chk_flag(sleep, 1'b1, "sleep in reset");
		chk_flag(rx_term | tx_term, 1'b0, "terms in reset");
		arst_n = 1'b1;
		$display("test reset done");
		// Power-up detection with both receivers present
		wait_until(S_DET, 1'b1, WK + 10, n);
		chk_flag(rx_term, 1'b0, "rx term during detect");
		chk_flag(tx_term, 1'b0, "tx term during detect");
		wait_until(S_DET, 1'b0, DET_CYC + 10, n);
		chk_flag(rx_term & tx_term, 1'b1, "terms after found");
		chk_flag(pwr_down, 1'b0, "power after found");
		// Idle flags start set; first activity releases both outputs
		{act1, act2} = 2'h3;
		step(4);
		chk_flag(txi1 | txi2, 1'b0, "tx idle after activity");
		{act1, act2} = 2'h0;
		$display("test detect done");
		// Every pin code combination on both channels, code 3 as mid
		for (int i = 0; i < 64; i++)
		begin
			{sw1, bo1, de1} = i[5:0];
			{sw2, bo2, de2} = {i[1:0], i[5:4], i[3:2]};
			step(4);
			chk_set({1'b0, swing1}, {1'b0, exp_sw(sw1)}, "sw1");
			chk_set({1'b0, swing2}, {1'b0, exp_sw(sw2)}, "sw2");
			chk_set({1'b0, boost1}, {1'b0, exp_eq(bo1)}, "eq1");
			chk_set({1'b0, boost2}, {1'b0, exp_eq(bo2)}, "eq2");
			chk_set(deem1, exp_de(de1, sw1), "de1");
			chk_set(deem2, exp_de(de2, sw2), "de2");
		end
		small_pkg = 1'b1;
		{sw2, de2} = {PIN_LOW, PIN_LOW};
		step(4);
		chk_set({1'b0, swing2}, {1'b0, SW_1241}, "small sw2");
		chk_set(deem2, DE_M3DB, "small de2");
		small_pkg = 1'b0;
		$display("test settings done");
		// Idle per channel, then U-state entry and LFPS wake
		idl1 = 1'b1;
		step(4);
		chk_flag(txi1, 1'b1, "tx idle ch1");
		chk_flag(txi2, 1'b0, "tx idle ch2 early");
		idl2 = 1'b1;
		wait_until(S_LPW, 1'b1, UIDLE_CYC + 20, n);
		chk_flag(n >= UIDLE_CYC - 10, 1'b1, "u-state entry early");
		{idl1, act1} = 2'h1;
		wait_until(S_LPW, 1'b0, 10, n);
		step(2);
		chk_flag(txi1, 1'b0, "tx idle ch1 release");
		{idl1, act1} = 2'h2;
		wait_until(S_LPW, 1'b1, UIDLE_CYC + 20, n);
		$display("test u-state done");
		// Periodic detection in the low-power state
		wait_until(S_DET, 1'b1, PL + 10, n);
		chk_flag(rx_term & low_pwr, 1'b1, "poll keeps rx term");
		wait_until(S_DET, 1'b0, DET_CYC + 10, n);
		chk_flag(low_pwr & rx_term, 1'b1, "poll found");
		rcv2 = 1'b0;
		wait_until(S_DET, 1'b1, PL + 10, n);
		wait_until(S_RXT, 1'b0, DET_CYC + 10, n);
		chk_flag(det_req, 1'b1, "redetect after lost");
		chk_flag(low_pwr, 1'b0, "low power after lost");
		$display("test poll done");
		// Failed detection, retry interval, then reconnection
		wait_until(S_DET, 1'b0, DET_CYC + 10, n);
		chk_flag(tx_term, 1'b0, "tx high-z on fail");
		chk_flag(pwr_down, 1'b1, "power down on fail");
		// Clock enable low freezes the retry timer
		clk_en = 1'b0;
		step(RT + 20);
		chk_flag(det_req, 1'b0, "retry ran while frozen");
		clk_en = 1'b1;
		wait_until(S_DET, 1'b1, RT + 10, n);
		chk_flag(n >= RT - 5, 1'b1, "retry too soon");
		rcv2 = 1'b1;
		wait_until(S_DET, 1'b0, DET_CYC + 10, n);
		chk_flag(tx_term & rx_term, 1'b1, "reconnected");
		$display("test retry done");
		// Sleep entry and exit through the enable pin
		enable = 1'b0;
		wait_until(S_SLP, 1'b1, DIS_CYC, n);
		chk_flag(rx_term | tx_term, 1'b0, "terms in sleep");
		enable = 1'b1;
		wait_until(S_DET, 1'b1, WK + 10, n);
		chk_flag(sleep, 1'b0, "sleep after wake");
		$display("test sleep done");
		close_out();
	end
endmodule
